// ===== phy_ctrl_pkg.sv
// Operation
// - Soft reset bit resets, self-clears within 200us
// - Control register reads 0x3000 after reset, 0x3400 with strap all ones
// - Speed bit one selects 100, zero 10
// - Speed bit applies only without autonegotiation
// - Speed strap overrides speed bit
// - Autonegotiation strap overrides enable bit 12
// - MII disable inverted; strap not ones clears default
// - Restart bit restarts negotiation, clears when done
// - Duplex bit, autoneg off only, strap overrides
// - Status register read-only, reads 0x7809
// - Status bit 14 reports 100 full capability
// - Status bit 13 reports 100 half capability
// - Self-clearing fields read back, clear when done
package phy_ctrl_pkg;

    localparam int          MGMT_ADDR_W     = 5;
    localparam int          REG_W           = 16;
    localparam int          STRAP_W         = 4;

    localparam logic [4:0]  BASIC_CONTROL   = 5'h00;
    localparam logic [4:0]  BASIC_STATUS    = 5'h01;

    localparam logic [15:0] CONTROL_RESET   = 16'h3000;
    localparam logic [15:0] STATUS_VALUE    = 16'h7809;
    localparam logic [15:0] CONTROL_WR_MASK = 16'hff80;

    localparam int          SOFT_RESET_BIT  = 15;
    localparam int          LOOPBACK_BIT    = 14;
    localparam int          SPEED_BIT       = 13;
    localparam int          AUTONEG_EN_BIT  = 12;
    localparam int          POWER_DOWN_BIT  = 11;
    localparam int          MII_PORT_BIT    = 10;
    localparam int          AUTONEG_RST_BIT = 9;
    localparam int          DUPLEX_BIT      = 8;
    localparam int          COL_TEST_BIT    = 7;

    localparam logic [3:0]  STRAP_ALL_ONES  = 4'hf;

    localparam int          CLK_PERIOD_NS   = 4;
    localparam int          SELF_CLEAR_US   = 200;
    // Longest time, rounded down
    localparam int          SELF_CLEAR_CYCLES = (SELF_CLEAR_US * 1000) / CLK_PERIOD_NS;
    localparam int          SOFT_RESET_HOLD = 64;

endpackage

// ===== reset_sync.sv
`timescale 1ns/10ps
module reset_sync (
    input  wire logic ref_clk,
    input  wire logic nrst,
    output logic      rstSyncN
);
    typedef struct packed {
        logic [1:0] stage;
    } sync_state_t;

    sync_state_t stateQ;
    sync_state_t stateD;

    always_comb begin
        stateD       = stateQ;
        stateD.stage = {stateQ.stage[0], 1'b1};
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stateQ <= '0;
        end else begin
            stateQ <= stateD;
        end
    end

    assign rstSyncN = stateQ.stage[1];
endmodule // reset_sync

// ===== self_clear_timer.sv
`timescale 1ns/10ps
module self_clear_timer #(
    parameter int HOLD_CYCLES = 64
) (
    input  wire logic ref_clk,
    input  wire logic rstN,
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    localparam int CW = $clog2(HOLD_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(HOLD_CYCLES - 1);

    typedef struct packed {
        logic [CW-1:0] count;
        logic          busy;
    } timer_state_t;

    timer_state_t stateQ;
    timer_state_t stateD;

    always_comb begin
        stateD = stateQ;
        done   = 1'b0;
        if (stateQ.busy) begin
            if (stateQ.count == LAST) begin
                stateD.busy  = 1'b0;
                stateD.count = '0;
                done         = 1'b1;
            end else begin
                stateD.count = stateQ.count + CW'(1);
            end
        end else if (start) begin
            stateD.busy  = 1'b1;
            stateD.count = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            stateQ <= '0;
        end else begin
            stateQ <= stateD;
        end
    end

    assign busy = stateQ.busy;
endmodule // self_clear_timer

// ===== phy_control_status_regs.sv
`timescale 1ns/10ps
module phy_control_status_regs #(
    parameter int SOFT_RESET_HOLD   = phy_ctrl_pkg::SOFT_RESET_HOLD,
    parameter int SELF_CLEAR_CYCLES = phy_ctrl_pkg::SELF_CLEAR_CYCLES
) (
    input  wire logic                                ref_clk,
    input  wire logic                                nrst,
    input  wire logic [phy_ctrl_pkg::MGMT_ADDR_W-1:0] mgmtAddr,
    input  wire logic                                mgmtWrite,
    input  wire logic [phy_ctrl_pkg::REG_W-1:0]       mgmtWrData,
    input  wire logic                                mgmtRead,
    output logic      [phy_ctrl_pkg::REG_W-1:0]       mgmtRdData,
    input  wire logic [phy_ctrl_pkg::STRAP_W-1:0]     mgmtAddressStrap,
    input  wire logic                                speedStrap,
    input  wire logic                                duplexStrap,
    input  wire logic                                autonegStrapPin,
    input  wire logic                                resolvedSpeed100,
    input  wire logic                                resolvedFullDuplex,
    input  wire logic                                autonegRestartDone,
    output logic                                     phySoftReset,
    output logic                                     loopbackEnable,
    output logic                                     powerDownEnable,
    output logic                                     collisionTestEnable,
    output logic                                     miiPortDisable,
    output logic                                     autonegEnable,
    output logic                                     autonegRestart,
    output logic                                     speed100,
    output logic                                     fullDuplex
);
    import phy_ctrl_pkg::*;

    // Soft reset must end well inside the self-clear limit
    localparam int SoftClearMax = SOFT_RESET_HOLD + 1;

    typedef struct packed {
        logic [REG_W-1:0]   ctrl;
        logic [STRAP_W-1:0] strap;
        logic               strapTaken;
        logic [REG_W-1:0]   rdData;
    } regs_state_t;

    regs_state_t stateQ;
    regs_state_t stateD;

    logic rstSyncN;
    logic resetBusy;
    logic resetDone;
    logic ctrlWrite;
    logic resetStart;

    function automatic logic [REG_W-1:0] ctrlDefault(input logic [STRAP_W-1:0] strap);
        logic [REG_W-1:0] value;
        value               = CONTROL_RESET;
        value[MII_PORT_BIT] = (strap == STRAP_ALL_ONES);
        return value;
    endfunction

    function automatic logic [REG_W-1:0] readMux(input logic [MGMT_ADDR_W-1:0] addr,
                                                  input logic [REG_W-1:0]       ctrl);
        logic [REG_W-1:0] value;
        value = '0;
        case (addr)
            BASIC_CONTROL: value = ctrl;
            BASIC_STATUS:  value = STATUS_VALUE;
            default:       value = '0;
        endcase
        return value;
    endfunction

    reset_sync u_reset_sync (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .rstSyncN (rstSyncN)
    );

    self_clear_timer #(
        .HOLD_CYCLES (SOFT_RESET_HOLD)
    ) u_soft_reset_timer (
        .ref_clk (ref_clk),
        .rstN    (rstSyncN),
        .start   (resetStart),
        .busy    (resetBusy),
        .done    (resetDone)
    );

    // Writes during a soft reset are dropped: the register is about to be reloaded anyway
    assign ctrlWrite  = mgmtWrite && !resetBusy && (mgmtAddr == BASIC_CONTROL);
    assign resetStart = ctrlWrite && mgmtWrData[SOFT_RESET_BIT];

    always_comb begin
        stateD = stateQ;
        // Strap caught once, first cycle after reset release
        if (!stateQ.strapTaken) begin
            stateD.strapTaken        = 1'b1;
            stateD.strap             = mgmtAddressStrap;
            stateD.ctrl[MII_PORT_BIT] = (mgmtAddressStrap == STRAP_ALL_ONES);
        end
        if (autonegRestartDone) begin
            stateD.ctrl[AUTONEG_RST_BIT] = 1'b0;
        end
        if (ctrlWrite) begin
            // Low bits stay zero whatever is written
            stateD.ctrl = (mgmtWrData & CONTROL_WR_MASK) | (stateQ.ctrl & ~CONTROL_WR_MASK);
            // Set wins over the completion clear
            stateD.ctrl[AUTONEG_RST_BIT] = mgmtWrData[AUTONEG_RST_BIT]
                || (stateQ.ctrl[AUTONEG_RST_BIT] && !autonegRestartDone);
        end
        if (resetDone) begin
            stateD.ctrl = ctrlDefault(stateQ.strap);
        end
        if (mgmtRead) begin
            stateD.rdData = readMux(mgmtAddr, stateQ.ctrl);
        end
    end

    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            stateQ      <= '0;
            stateQ.ctrl <= CONTROL_RESET;
        end else begin
            stateQ <= stateD;
        end
    end

    assign mgmtRdData          = stateQ.rdData;
    assign phySoftReset        = resetBusy;
    assign loopbackEnable      = stateQ.ctrl[LOOPBACK_BIT];
    assign powerDownEnable     = stateQ.ctrl[POWER_DOWN_BIT];
    assign collisionTestEnable = stateQ.ctrl[COL_TEST_BIT];
    assign miiPortDisable      = !stateQ.ctrl[MII_PORT_BIT];
    assign autonegRestart      = stateQ.ctrl[AUTONEG_RST_BIT];
    assign autonegEnable       = stateQ.ctrl[AUTONEG_EN_BIT] || autonegStrapPin;
    assign speed100 = autonegEnable ? resolvedSpeed100
                                    : (stateQ.ctrl[SPEED_BIT] || speedStrap);
    assign fullDuplex = autonegEnable ? resolvedFullDuplex
                                      : (stateQ.ctrl[DUPLEX_BIT] || duplexStrap);

    property p_soft_reset_clears;
        @(posedge ref_clk) disable iff (!rstSyncN)
        resetStart |=> stateQ.ctrl[SOFT_RESET_BIT] && phySoftReset
            ##[1:SoftClearMax] (!stateQ.ctrl[SOFT_RESET_BIT] && !phySoftReset);
    endproperty
    a_soft_reset_clears: assert property (p_soft_reset_clears)
        else $error("soft reset bit did not self-clear in time");

    property p_reset_value;
        @(posedge ref_clk) disable iff (!rstSyncN)
        !stateQ.strapTaken |-> (stateQ.ctrl == CONTROL_RESET);
    endproperty
    a_reset_value: assert property (p_reset_value)
        else $error("control register not at reset value");

    property p_speed_manual;
        @(posedge ref_clk) disable iff (!rstSyncN)
        (!autonegEnable && !speedStrap) |-> (speed100 == stateQ.ctrl[SPEED_BIT]);
    endproperty
    a_speed_manual: assert property (p_speed_manual)
        else $error("speed does not follow speed bit");

    property p_speed_autoneg;
        @(posedge ref_clk) disable iff (!rstSyncN)
        autonegEnable |-> (speed100 == resolvedSpeed100);
    endproperty
    a_speed_autoneg: assert property (p_speed_autoneg)
        else $error("speed bit applied during autonegotiation");

    property p_speed_strap;
        @(posedge ref_clk) disable iff (!rstSyncN)
        (!autonegEnable && speedStrap) |-> speed100;
    endproperty
    a_speed_strap: assert property (p_speed_strap)
        else $error("speed strap ignored");

    property p_autoneg_strap;
        @(posedge ref_clk) disable iff (!rstSyncN)
        autonegStrapPin |-> autonegEnable;
    endproperty
    a_autoneg_strap: assert property (p_autoneg_strap)
        else $error("autonegotiation strap ignored");

    property p_mii_strap;
        @(posedge ref_clk) disable iff (!rstSyncN)
        !stateQ.strapTaken |=> (miiPortDisable == ($past(mgmtAddressStrap) != STRAP_ALL_ONES));
    endproperty
    a_mii_strap: assert property (p_mii_strap)
        else $error("MII disable default wrong for strap");

    property p_restart_cycle;
        @(posedge ref_clk) disable iff (!rstSyncN)
        ((ctrlWrite && mgmtWrData[AUTONEG_RST_BIT])
            || (autonegRestart && !autonegRestartDone && !resetDone)) |=> autonegRestart;
    endproperty
    a_restart_cycle: assert property (p_restart_cycle)
        else $error("restart bit dropped before completion");

    property p_restart_clear;
        @(posedge ref_clk) disable iff (!rstSyncN)
        (autonegRestartDone && !(ctrlWrite && mgmtWrData[AUTONEG_RST_BIT])) |=> !autonegRestart;
    endproperty
    a_restart_clear: assert property (p_restart_clear)
        else $error("restart bit not cleared on completion");

    property p_duplex;
        @(posedge ref_clk) disable iff (!rstSyncN)
        !autonegEnable |-> (fullDuplex == (stateQ.ctrl[DUPLEX_BIT] || duplexStrap));
    endproperty
    a_duplex: assert property (p_duplex)
        else $error("duplex selection wrong");

    property p_status_read;
        @(posedge ref_clk) disable iff (!rstSyncN)
        (mgmtRead && mgmtAddr == BASIC_STATUS) |=> (mgmtRdData == STATUS_VALUE)
            && mgmtRdData[14] && mgmtRdData[13];
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status register read wrong value");

    property p_low_bits_zero;
        @(posedge ref_clk) disable iff (!rstSyncN)
        ctrlWrite |=> (stateQ.ctrl[6:0] == 7'h00) && (loopbackEnable == $past(mgmtWrData[14]));
    endproperty
    a_low_bits_zero: assert property (p_low_bits_zero)
        else $error("control write not stored as expected");

    // Everything but the strap-dependent bit must return to its default
    property p_reload_after_reset;
        @(posedge ref_clk) disable iff (!rstSyncN)
        resetDone |=> ((stateQ.ctrl & ~(REG_W'(1) << MII_PORT_BIT))
            == (CONTROL_RESET & ~(REG_W'(1) << MII_PORT_BIT)))
            && (miiPortDisable == (stateQ.strap != STRAP_ALL_ONES));
    endproperty
    a_reload_after_reset: assert property (p_reload_after_reset)
        else $error("soft reset did not reload control defaults");

    property p_soft_reset_hold;
        @(posedge ref_clk) disable iff (!rstSyncN)
        (resetBusy && !resetDone) |=> phySoftReset && stateQ.ctrl[SOFT_RESET_BIT];
    endproperty
    a_soft_reset_hold: assert property (p_soft_reset_hold)
        else $error("soft reset dropped early");

    property p_write_dropped_busy;
        @(posedge ref_clk) disable iff (!rstSyncN)
        (mgmtWrite && resetBusy && !resetDone && !autonegRestartDone)
            |=> $stable(stateQ.ctrl);
    endproperty
    a_write_dropped_busy: assert property (p_write_dropped_busy)
        else $error("control write taken during soft reset");

    property p_ctrl_read;
        @(posedge ref_clk) disable iff (!rstSyncN)
        (mgmtRead && mgmtAddr == BASIC_CONTROL) |=> (mgmtRdData == $past(stateQ.ctrl));
    endproperty
    a_ctrl_read: assert property (p_ctrl_read)
        else $error("control read does not return stored value");

    property p_read_hold;
        @(posedge ref_clk) disable iff (!rstSyncN)
        !mgmtRead |=> $stable(mgmtRdData);
    endproperty
    a_read_hold: assert property (p_read_hold)
        else $error("read data changed without a read");

    property p_unmapped_read;
        @(posedge ref_clk) disable iff (!rstSyncN)
        (mgmtRead && mgmtAddr != BASIC_CONTROL && mgmtAddr != BASIC_STATUS)
            |=> (mgmtRdData == '0);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped address read nonzero");

    property p_reserved_zero;
        @(posedge ref_clk) disable iff (!rstSyncN)
        (stateQ.ctrl[COL_TEST_BIT-1:0] == '0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved control bits not zero");

    property p_mode_write;
        @(posedge ref_clk) disable iff (!rstSyncN)
        ctrlWrite |=> (powerDownEnable == $past(mgmtWrData[POWER_DOWN_BIT]))
            && (collisionTestEnable == $past(mgmtWrData[COL_TEST_BIT]));
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("mode enables not stored as written");

    property p_speed_write;
        @(posedge ref_clk) disable iff (!rstSyncN)
        ctrlWrite |=> (stateQ.ctrl[SPEED_BIT] == $past(mgmtWrData[SPEED_BIT]));
    endproperty
    a_speed_write: assert property (p_speed_write)
        else $error("speed bit not stored as written");

    property p_autoneg_bit;
        @(posedge ref_clk) disable iff (!rstSyncN)
        !autonegStrapPin |-> (autonegEnable == stateQ.ctrl[AUTONEG_EN_BIT]);
    endproperty
    a_autoneg_bit: assert property (p_autoneg_bit)
        else $error("autonegotiation enable does not follow its bit");

    property p_duplex_autoneg;
        @(posedge ref_clk) disable iff (!rstSyncN)
        autonegEnable |-> (fullDuplex == resolvedFullDuplex);
    endproperty
    a_duplex_autoneg: assert property (p_duplex_autoneg)
        else $error("duplex bit applied during autonegotiation");

    property p_mii_write;
        @(posedge ref_clk) disable iff (!rstSyncN)
        ctrlWrite |=> (miiPortDisable == !$past(mgmtWrData[MII_PORT_BIT]));
    endproperty
    a_mii_write: assert property (p_mii_write)
        else $error("MII disable sense wrong after write");

    // The strap is caught once; a soft reset must not take it again
    property p_strap_once;
        @(posedge ref_clk) disable iff (!rstSyncN)
        stateQ.strapTaken |=> (stateQ.strapTaken && $stable(stateQ.strap));
    endproperty
    a_strap_once: assert property (p_strap_once)
        else $error("address strap changed after capture");
endmodule // phy_control_status_regs

// ===== mgmt_ctrl_model.sv
`timescale 1ns/10ps
module mgmt_ctrl_model (
    input  wire logic                                 ref_clk,
    output logic      [phy_ctrl_pkg::MGMT_ADDR_W-1:0] mgmtAddr,
    output logic                                      mgmtWrite,
    output logic      [phy_ctrl_pkg::REG_W-1:0]       mgmtWrData,
    output logic                                      mgmtRead,
    input  wire logic [phy_ctrl_pkg::REG_W-1:0]       mgmtRdData
);
    import phy_ctrl_pkg::*;
    initial begin
        mgmtAddr   = '0;
        mgmtWrite  = 1'b0;
        mgmtWrData = '0;
        mgmtRead   = 1'b0;
    end
    // Low bits always written as zero, other values are unsupported
    task automatic wr(input logic [MGMT_ADDR_W-1:0] addr, input logic [REG_W-1:0] data);
        @(posedge ref_clk);
        mgmtAddr   <= addr;
        mgmtWrData <= data & CONTROL_WR_MASK;
        mgmtWrite  <= 1'b1;
        @(posedge ref_clk);
        mgmtWrite  <= 1'b0;
        // Stale data would hide a late sample, so turn it over
        mgmtWrData <= ~(data & CONTROL_WR_MASK);
        #1;
    endtask
    task automatic rd(input logic [MGMT_ADDR_W-1:0] addr, output logic [REG_W-1:0] data);
        @(posedge ref_clk);
        mgmtAddr <= addr;
        mgmtRead <= 1'b1;
        @(posedge ref_clk);
        mgmtRead <= 1'b0;
        #1;
        data = mgmtRdData;
    endtask
endmodule // mgmt_ctrl_model

// ===== phy_control_status_regs_tb.sv
`timescale 1ns/10ps
module phy_control_status_regs_tb;
    import phy_ctrl_pkg::*;
    localparam int HOLD = 4;
    logic ref_clk, nrst, mgmtWrite, mgmtRead;
    logic [MGMT_ADDR_W-1:0] mgmtAddr;
    logic [REG_W-1:0] mgmtWrData, mgmtRdData, rdVal;
    logic [STRAP_W-1:0] mgmtAddressStrap;
    logic speedStrap, duplexStrap, autonegStrapPin;
    logic resolvedSpeed100, resolvedFullDuplex, autonegRestartDone;
    logic phySoftReset, loopbackEnable, powerDownEnable, collisionTestEnable;
    logic miiPortDisable, autonegEnable, autonegRestart, speed100, fullDuplex;
    int miscompares = 0;
    int nCompared = 0;
    // Bits: soft reset, loopback, power down, collision, mii off, an, restart, speed, duplex
    wire [8:0] outs = {phySoftReset, loopbackEnable, powerDownEnable, collisionTestEnable,
                       miiPortDisable, autonegEnable, autonegRestart, speed100, fullDuplex};

    phy_control_status_regs #(.SOFT_RESET_HOLD(HOLD)) dut (
        .ref_clk(ref_clk), .nrst(nrst), .mgmtAddr(mgmtAddr), .mgmtWrite(mgmtWrite),
        .mgmtWrData(mgmtWrData), .mgmtRead(mgmtRead), .mgmtRdData(mgmtRdData),
        .mgmtAddressStrap(mgmtAddressStrap), .speedStrap(speedStrap),
        .duplexStrap(duplexStrap), .autonegStrapPin(autonegStrapPin),
        .resolvedSpeed100(resolvedSpeed100), .resolvedFullDuplex(resolvedFullDuplex),
        .autonegRestartDone(autonegRestartDone), .phySoftReset(phySoftReset),
        .loopbackEnable(loopbackEnable), .powerDownEnable(powerDownEnable),
        .collisionTestEnable(collisionTestEnable), .miiPortDisable(miiPortDisable),
        .autonegEnable(autonegEnable), .autonegRestart(autonegRestart),
        .speed100(speed100), .fullDuplex(fullDuplex));

    mgmt_ctrl_model mgmt (
        .ref_clk(ref_clk), .mgmtAddr(mgmtAddr), .mgmtWrite(mgmtWrite),
        .mgmtWrData(mgmtWrData), .mgmtRead(mgmtRead), .mgmtRdData(mgmtRdData));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        nCompared++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (miscompares == 0 && nCompared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic t_reset_values();
        mgmt.rd(BASIC_CONTROL, rdVal);
        chk(rdVal, 16'h3000);
        chk({7'h00, outs}, 16'h0019);
        mgmt.rd(BASIC_STATUS, rdVal);
        chk(rdVal, 16'h7809);
        chk({14'h0000, rdVal[14:13]}, 16'h0003);
        mgmt.wr(BASIC_STATUS, 16'h0000);
        mgmt.rd(BASIC_STATUS, rdVal);
        chk(rdVal, 16'h7809);
        mgmt.rd(5'h05, rdVal);
        chk(rdVal, 16'h0000);
    endtask

    task automatic t_modes();
        mgmt.wr(BASIC_CONTROL, 16'h4880);
        chk({7'h00, outs}, 16'h00f0);
        mgmt.rd(BASIC_CONTROL, rdVal);
        chk(rdVal, 16'h4880);
        mgmt.wr(BASIC_CONTROL, 16'h2500);
        chk({7'h00, outs}, 16'h0003);
        mgmt.rd(BASIC_CONTROL, rdVal);
        chk(rdVal, 16'h2500);
    endtask

    task automatic t_straps();
        mgmt.wr(BASIC_CONTROL, 16'h0000);
        chk({7'h00, outs}, 16'h0010);
        speedStrap  <= 1'b1;
        duplexStrap <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk({7'h00, outs}, 16'h0013);
        autonegStrapPin <= 1'b1;
        @(posedge ref_clk);
        #1;
        // Straps on speed and duplex are ignored under negotiation
        chk({7'h00, outs}, 16'h0019);
        resolvedSpeed100   <= 1'b1;
        resolvedFullDuplex <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk({7'h00, outs}, 16'h001a);
        resolvedSpeed100   <= 1'b0;
        resolvedFullDuplex <= 1'b1;
        speedStrap      <= 1'b0;
        duplexStrap     <= 1'b0;
        autonegStrapPin <= 1'b0;
    endtask

    task automatic t_restart();
        mgmt.wr(BASIC_CONTROL, 16'h1200);
        chk({7'h00, outs}, 16'h001d);
        mgmt.rd(BASIC_CONTROL, rdVal);
        chk(rdVal, 16'h1200);
        autonegRestartDone <= 1'b1;
        @(posedge ref_clk);
        autonegRestartDone <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk({7'h00, outs}, 16'h0019);
        mgmt.rd(BASIC_CONTROL, rdVal);
        chk(rdVal, 16'h1000);
    endtask

    task automatic t_soft_reset();
        int n;
        mgmt.wr(BASIC_CONTROL, 16'h4880);
        mgmt.wr(BASIC_CONTROL, 16'h8000);
        chk({15'h0000, phySoftReset}, 16'h0001);
        mgmt.wr(BASIC_CONTROL, 16'h4000);
        n = 0;
        while (phySoftReset !== 1'b0 && n < HOLD + 4) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk({15'h0000, phySoftReset}, 16'h0000);
        mgmt.rd(BASIC_CONTROL, rdVal);
        chk(rdVal, 16'h3000);
    endtask

    // Second reset with the strap all ones: MII stays enabled, also after soft reset
    task automatic t_strap_ones();
        @(posedge ref_clk);
        nrst             <= 1'b0;
        mgmtAddressStrap <= 4'hf;
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        mgmt.rd(BASIC_CONTROL, rdVal);
        chk(rdVal, 16'h3400);
        chk({7'h00, outs}, 16'h0009);
        mgmt.wr(BASIC_CONTROL, 16'h8000);
        repeat (HOLD + 2) @(posedge ref_clk);
        mgmt.rd(BASIC_CONTROL, rdVal);
        chk(rdVal, 16'h3400);
    endtask

    initial begin
        nrst = 1'b0;
        mgmtAddressStrap = 4'h5;
        speedStrap = 1'b0;
        duplexStrap = 1'b0;
        autonegStrapPin = 1'b0;
        resolvedSpeed100 = 1'b0;
        resolvedFullDuplex = 1'b1;
        autonegRestartDone = 1'b0;
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_reset_values();
        t_modes();
        t_straps();
        t_restart();
        t_soft_reset();
        t_strap_ones();
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        miscompares++;
        report_and_stop();
    end
endmodule // phy_control_status_regs_tb
